/* src/tsi_regs.svh */
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

// System clock and line rates
`define SYS_CLK_MHZ        50
`define MCLK_HZ            4096000
`define BIT_RATE_BPS       2048000

// Master-clock half periods in one bit cell
`define HALF_PER_BIT       (2 * `MCLK_HZ / `BIT_RATE_BPS)

// Bits in one channel, sample phase at three quarters of the cell
`define BITS_PER_CH        8
`define SAMPLE_PHASE       2'h2
`define LAST_PHASE         2'h3

// Least low time of the device reset pin, and its count in clk_in cycles
`define RESET_MIN_NS       100
`define RESET_MIN_CYC      ((`RESET_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)

// Widest frame pulse accepted, in master-clock half periods
`define FS_PULSE_MAX_HALF  4'h4

// Value captured into the scan instruction register
`define IR_CAPTURE         2'h1

// Depth of the connection write queue
`define CM_FIFO_DEPTH      8

`endif

/* src/tsi_pkg.sv */
package tsi_pkg;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR  = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UP_DR  = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR  = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UP_IR  = 16'h8000
  } tap_state_t;

endpackage

/* src/tsi_fifo.sv */
`timescale 1ns/1ns

module tsi_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             full_reg;
  logic             empty_reg;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && !full_reg;
  assign pop           = out_ready_in && !empty_reg;
  assign count_next    = count_reg + CW'(push) - CW'(pop);
  assign in_ready_out  = !full_reg;
  assign out_valid_out = !empty_reg;
  assign out_data_out  = mem_reg[rd_reg];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  // Flags registered so the filling side sees a clean ready
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
      full_reg  <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_reg + 1'b1);
      end
      count_reg <= count_next;
      full_reg  <= (count_next == CW'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end

endmodule

/* src/tsi_switch_pin_control.sv */
`timescale 1ns/1ns
`include "tsi_regs.svh"

// Notes on behaviour
// - Any input channel to any output channel
// - Streams run at half the master clock
// - Frame pulse polarity picks the frame format
// - Device reset clears stream state but keeps queued connection writes, floats all stream outputs
// - Scan output changes on falling scan clock
// - Scan output floats outside shift states
// - Scan reset pin forces reset state immediately
// - Boundary and sample edges follow frame format
module tsi_switch_pin_control
  import tsi_pkg::*;
#(
  parameter int STREAMS  = 32,
  parameter int CHANNELS = 32
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                reset_n_in,
  input  wire logic                mclk_in,
  input  wire logic                frame_sync_in,
  input  wire logic [STREAMS-1:0]  serial_in_streams_in,
  output logic      [STREAMS-1:0]  serial_out_streams_out,
  output logic      [STREAMS-1:0]  serial_out_oe_n_out,
  output logic                     frame_gci_out,
  output logic                     frame_locked_out,
  input  wire logic                cm_valid_in,
  input  wire logic [$clog2(STREAMS*CHANNELS)-1:0] cm_dest_in,
  input  wire logic [$clog2(STREAMS*CHANNELS)-1:0] cm_src_in,
  output logic                     cm_ready_out,
  input  wire logic                tck_in,
  input  wire logic                tms_in,
  input  wire logic                tdi_in,
  input  wire logic                trst_n_in,
  output logic                     tdo_out,
  output logic                     tdo_oe_n_out
);

  localparam int W      = `BITS_PER_CH;
  localparam int SW     = $clog2(STREAMS);
  localparam int CW     = $clog2(CHANNELS);
  localparam int AW     = $clog2(STREAMS * CHANNELS);
  localparam int PW     = STREAMS + 6;
  localparam int RSTMIN = `RESET_MIN_CYC;

  function automatic logic [AW-1:0] mem_index(input logic [SW-1:0] st,
                                               input logic [CW-1:0] ch);
    mem_index = AW'(int'(st) * CHANNELS + int'(ch));
  endfunction

  function automatic tap_state_t tap_next(input tap_state_t st, input logic tms);
    unique case (st)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction

  // Pin synchronisers; stage one is read only by stage two
  logic [PW-1:0]      pin_s1_reg;
  logic [PW-1:0]      pin_s2_reg;
  logic               rst_pin_s;
  logic               mclk_s;
  logic               fs_s;
  logic               tck_s;
  logic               tms_s;
  logic               tdi_s;
  logic [STREAMS-1:0] rx_s;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {reset_n_in, mclk_in, frame_sync_in, tck_in, tms_in, tdi_in,
                     serial_in_streams_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign {rst_pin_s, mclk_s, fs_s, tck_s, tms_s, tdi_s, rx_s} = pin_s2_reg;

  // Device reset qualified by its least low time; shorter glitches ignored
  logic [7:0] rst_cnt_reg;
  logic       dev_rst_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_cnt_reg <= '0;
      dev_rst_reg <= 1'b1;
    end else if (rst_pin_s) begin
      rst_cnt_reg <= '0;
      dev_rst_reg <= 1'b0;
    end else if (rst_cnt_reg == 8'(RSTMIN - 1)) begin
      dev_rst_reg <= 1'b1;
    end else begin
      rst_cnt_reg <= rst_cnt_reg + 8'h01;
    end
  end

  // Master clock edges, sampled; clk_in is over ten times faster
  logic mclk_d_reg;
  logic fs_d_reg;
  logic tck_d_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mclk_d_reg <= 1'b0;
      fs_d_reg   <= 1'b0;
      tck_d_reg  <= 1'b0;
    end else begin
      mclk_d_reg <= mclk_s;
      fs_d_reg   <= fs_s;
      tck_d_reg  <= tck_s;
    end
  end

  logic mclk_rise;
  logic mclk_fall;
  logic half_tick;
  logic fs_edge;
  logic tck_rise;
  logic tck_fall;

  assign mclk_rise = mclk_s && !mclk_d_reg;
  assign mclk_fall = !mclk_s && mclk_d_reg;
  assign half_tick = mclk_rise || mclk_fall;
  assign fs_edge   = fs_s ^ fs_d_reg;
  assign tck_rise  = tck_s && !tck_d_reg;
  assign tck_fall  = !tck_s && tck_d_reg;

  // Frame pulse: a short excursion; its level gives the format
  logic [3:0] fs_width_reg;
  logic       fmt_gci_reg;
  logic       locked_reg;
  logic       align_pending_reg;
  logic       pulse_end;
  logic       bnd_edge;
  logic       realign;

  assign pulse_end = fs_edge && (fs_width_reg <= `FS_PULSE_MAX_HALF);
  assign bnd_edge  = fmt_gci_reg ? mclk_rise : mclk_fall;
  assign realign   = align_pending_reg && bnd_edge;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fs_width_reg      <= 4'hf;
      fmt_gci_reg       <= 1'b0;
      locked_reg        <= 1'b0;
      align_pending_reg <= 1'b0;
    end else if (dev_rst_reg) begin
      fs_width_reg      <= 4'hf;
      fmt_gci_reg       <= 1'b0;
      locked_reg        <= 1'b0;
      align_pending_reg <= 1'b0;
    end else begin
      if (fs_edge) begin
        fs_width_reg <= '0;
      end else if (half_tick && fs_width_reg != 4'hf) begin
        fs_width_reg <= fs_width_reg + 4'h1;
      end
      if (pulse_end) begin
        fmt_gci_reg       <= fs_d_reg;
        locked_reg        <= 1'b1;
        align_pending_reg <= 1'b1;
      end else if (realign) begin
        align_pending_reg <= 1'b0;
      end
    end
  end

  // Bit cell timing: four half periods per bit
  logic [1:0]    half_reg;
  logic [2:0]    bit_reg;
  logic [CW-1:0] ch_reg;
  logic [CW-1:0] ch_new;
  logic          sample_tick;
  logic          bit_start;
  logic          chan_start;

  assign sample_tick = half_tick && !realign && half_reg == `SAMPLE_PHASE;
  assign bit_start   = realign || (half_tick && half_reg == `LAST_PHASE);
  assign chan_start  = realign || (bit_start && bit_reg == 3'(W - 1));
  assign ch_new      = realign ? '0 : CW'(ch_reg + 1'b1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_reg <= '0;
      bit_reg  <= '0;
      ch_reg   <= '0;
    end else if (dev_rst_reg || realign) begin
      half_reg <= '0;
      bit_reg  <= '0;
      ch_reg   <= '0;
    end else if (half_tick) begin
      half_reg <= half_reg + 2'h1;
      if (half_reg == `LAST_PHASE) begin
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'(W - 1)) begin
          ch_reg <= ch_new;
        end
      end
    end
  end

  // Connection writes queue up and land only at bit boundaries
  logic          q_valid;
  logic [AW-1:0] q_dest;
  logic [AW-1:0] q_src;
  logic          q_pop;

  assign q_pop = bit_start && !dev_rst_reg;

  tsi_fifo #(
    .WIDTH (2 * AW),
    .DEPTH (`CM_FIFO_DEPTH)
  ) u_cm_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (cm_valid_in),
    .in_data_in    ({cm_dest_in, cm_src_in}),
    .in_ready_out  (cm_ready_out),
    .out_valid_out (q_valid),
    .out_data_out  ({q_dest, q_src}),
    .out_ready_in  (q_pop)
  );

  // Data and connection memories in flops; identity map after reset
  logic [W-1:0]  dm_reg [STREAMS*CHANNELS];
  logic [AW-1:0] cm_reg [STREAMS*CHANNELS];
  logic [W-1:0]  in_shift_reg  [STREAMS];
  logic [W-1:0]  out_shift_reg [STREAMS];
  logic [W-1:0]  load_byte     [STREAMS];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < STREAMS * CHANNELS; i++) begin
        dm_reg[i] <= '0;
        cm_reg[i] <= AW'(i);
      end
    end else if (dev_rst_reg) begin
      for (int i = 0; i < STREAMS * CHANNELS; i++) begin
        dm_reg[i] <= '0;
        cm_reg[i] <= AW'(i);
      end
    end else begin
      if (sample_tick && bit_reg == 3'(W - 1)) begin
        for (int s = 0; s < STREAMS; s++) begin
          dm_reg[mem_index(SW'(s), ch_reg)] <= {in_shift_reg[s][W-2:0], rx_s[s]};
        end
      end
      if (q_pop && q_valid) begin
        cm_reg[q_dest] <= q_src;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < STREAMS; g++) begin : g_stream
      assign load_byte[g] = dm_reg[cm_reg[mem_index(SW'(g), ch_new)]];

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          in_shift_reg[g]  <= '0;
          out_shift_reg[g] <= '0;
        end else if (dev_rst_reg) begin
          in_shift_reg[g]  <= '0;
          out_shift_reg[g] <= '0;
        end else begin
          if (sample_tick) begin
            in_shift_reg[g] <= {in_shift_reg[g][W-2:0], rx_s[g]};
          end
          if (chan_start) begin
            out_shift_reg[g] <= load_byte[g];
          end else if (bit_start) begin
            out_shift_reg[g] <= {out_shift_reg[g][W-2:0], 1'b0};
          end
        end
      end

      assign serial_out_streams_out[g] = out_shift_reg[g][W-1];

      a_switch_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (chan_start && !dev_rst_reg) |=> serial_out_streams_out[g] == $past(load_byte[g][W-1]))
        else $error("Output stream did not take the mapped byte");
    end
  endgenerate

  // Outputs float until reset ends and a frame is found
  logic [STREAMS-1:0] oe_n_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_n_reg <= '1;
    end else begin
      oe_n_reg <= {STREAMS{dev_rst_reg || !locked_reg}};
    end
  end

  assign serial_out_oe_n_out = oe_n_reg;
  assign frame_gci_out       = fmt_gci_reg;
  assign frame_locked_out    = locked_reg;

  // Scan port; scan reset pin acts without any clock
  tap_state_t tap_reg;
  logic [1:0] ir_sh_reg;
  logic       byp_reg;
  logic       tdo_reg;
  logic       tdo_oe_n_reg;

  always_ff @(posedge clk_in or posedge rst_in or negedge trst_n_in) begin
    if (rst_in || !trst_n_in) begin
      tap_reg   <= TAP_RESET;
      ir_sh_reg <= `IR_CAPTURE;
      byp_reg   <= 1'b0;
    end else if (tck_rise) begin
      tap_reg <= tap_next(tap_reg, tms_s);
      if (tap_reg == TAP_CAP_IR) begin
        ir_sh_reg <= `IR_CAPTURE;
      end else if (tap_reg == TAP_SH_IR) begin
        ir_sh_reg <= {tdi_s, ir_sh_reg[1]};
      end
      byp_reg <= (tap_reg == TAP_SH_DR) && tdi_s;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in or negedge trst_n_in) begin
    if (rst_in || !trst_n_in) begin
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_reg <= !(tap_reg == TAP_SH_IR || tap_reg == TAP_SH_DR);
      tdo_reg      <= (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : byp_reg;
    end
  end

  assign tdo_out      = tdo_reg;
  assign tdo_oe_n_out = tdo_oe_n_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_reset_float: assert property (dev_rst_reg |=> serial_out_oe_n_out == '1)
    else $error("Stream outputs driven during device reset");

  a_reset_width: assert property ($rose(dev_rst_reg) |->
    !$past(rst_pin_s, 1) && !$past(rst_pin_s, 3) && !$past(rst_pin_s, 5))
    else $error("Device reset taken on a pulse shorter than the least width");

  a_format_pick: assert property (pulse_end && !dev_rst_reg |=>
    frame_gci_out == $past(fs_d_reg) && frame_locked_out)
    else $error("Frame format not taken from the pulse level");

  a_sample_edge: assert property (sample_tick |->
    (fmt_gci_reg ? mclk_fall : mclk_rise))
    else $error("Input sampled on the wrong master clock edge");

  a_bit_cadence: assert property ((half_tick && !realign && !dev_rst_reg) |=>
    half_reg == $past(half_reg) + 2'h1 ##1 !half_tick)
    else $error("Bit cell phase did not advance by one half period");

  a_frame_align: assert property ((realign && !dev_rst_reg) |=>
    ch_reg == '0 && bit_reg == '0 && half_reg == '0 && !align_pending_reg)
    else $error("Channel counters not realigned to the frame pulse");

  a_tdo_change: assert property ($changed(tdo_out) |->
    $past(tck_fall) || !trst_n_in)
    else $error("Scan output changed away from a falling scan clock");

  a_tdo_float: assert property ($fell(tdo_oe_n_out) |->
    $past(tck_fall) && $past(tap_reg == TAP_SH_IR || tap_reg == TAP_SH_DR))
    else $error("Scan output driven outside a shift state");

  a_scan_reset: assert property (!trst_n_in |->
    tap_reg == TAP_RESET && tdo_oe_n_out)
    else $error("Scan controller not held in reset by the reset pin");

endmodule

/* tb/tdm_partner.sv */
`timescale 1ns/1ns

module tdm_partner #(
  parameter int HALF_NS = 122
) (
  input  wire logic        gci_in,
  input  wire logic [31:0] tx_in,
  input  wire logic [31:0] tx_oe_n_in,
  output logic             mclk_out,
  output logic             fs_out,
  output logic      [31:0] rx_out
);
  logic [7:0] got [32][32];
  logic       fmt_reg;
  int         h;

  function automatic logic [7:0] pat(input int s, input int c);
    return 8'(s * 37 + c * 11 + 90);
  endfunction

  function automatic logic pat_bit(input int s, input int c, input int k);
    logic [7:0] v;
    v = pat(s, c);
    return v[k];
  endfunction

  initial begin
    mclk_out = 1'h1;
    fs_out   = 1'h1;
    rx_out   = '0;
    fmt_reg  = 1'h0;
    // Odd start offset keeps pin edges off system clock edges
    #3;
    forever begin
      for (h = 0; h < 1024; h++) begin
        #HALF_NS;
        if (h == 0) fmt_reg = gci_in;
        // free master clock, boundary level on even halves
        mclk_out = (h % 2 == 0) ? fmt_reg : ~fmt_reg;
        // pulse of chosen polarity, two halves wide
        if (h == 1021) fs_out = fmt_reg;
        if (h == 1023) fs_out = ~fmt_reg;
        // one bit per two master clocks, MSB first
        if (h % 4 == 0) begin
          for (int s = 0; s < 32; s++) rx_out[s] = pat_bit(s, h / 32, 7 - (h / 4) % 8);
        end
        // sample three quarters into the cell; floated lines never match
        if (h % 4 == 3) begin
          for (int s = 0; s < 32; s++) begin
            got[s][h / 32][7 - (h / 4) % 8] = tx_oe_n_in[s] ? 1'hx : tx_in[s];
          end
        end
      end
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns

module tb_top;
  localparam int         FRAME_CYC = 6300;
  localparam logic [9:0] DEST      = 10'h065;
  localparam logic [9:0] SRC       = 10'h0E9;

  logic        clk_in, rst_in, reset_n_in, mclk_in, frame_sync_in, gci_mode;
  logic [31:0] rx, tx, tx_oe_n;
  logic        gci_out, locked, cm_valid, cm_ready;
  logic [9:0]  cm_dest, cm_src;
  logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  int          failures;
  int          checked;

  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end

  tsi_switch_pin_control dut (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .reset_n_in            (reset_n_in),
    .mclk_in               (mclk_in),
    .frame_sync_in         (frame_sync_in),
    .serial_in_streams_in  (rx),
    .serial_out_streams_out(tx),
    .serial_out_oe_n_out   (tx_oe_n),
    .frame_gci_out         (gci_out),
    .frame_locked_out      (locked),
    .cm_valid_in           (cm_valid),
    .cm_dest_in            (cm_dest),
    .cm_src_in             (cm_src),
    .cm_ready_out          (cm_ready),
    .tck_in                (tck),
    .tms_in                (tms),
    .tdi_in                (tdi),
    .trst_n_in             (trst_n),
    .tdo_out               (tdo),
    .tdo_oe_n_out          (tdo_oe_n)
  );

  tdm_partner far_end (
    .gci_in    (gci_mode),
    .tx_in     (tx),
    .tx_oe_n_in(tx_oe_n),
    .mclk_out  (mclk_in),
    .fs_out    (frame_sync_in),
    .rx_out    (rx)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic tck_cycle(input logic mode, input logic din);
    tms = mode;
    tdi = din;
    wait_cyc(5);
    tck = 1'h1;
    wait_cyc(5);
    tck = 1'h0;
    wait_cyc(5);
  endtask

  task automatic test_reset_state();
    check(tx_oe_n, 32'hFFFF_FFFF);
    check({tdo_oe_n, cm_ready, locked}, 3'h6);
    $display("test_reset_state done");
  endtask

  task automatic test_scan();
    check(tdo_oe_n, 1'h1);
    tck_cycle(1'h0, 1'h1);
    tck_cycle(1'h1, 1'h1);
    tck_cycle(1'h0, 1'h1);
    tck_cycle(1'h0, 1'h1);
    check({tdo_oe_n, tdo}, 2'h0);
    tck_cycle(1'h0, 1'h1);
    check({tdo_oe_n, tdo}, 2'h1);
    tck_cycle(1'h0, 1'h0);
    check({tdo_oe_n, tdo}, 2'h0);
    trst_n = 1'h0;
    wait_cyc(1);
    check(tdo_oe_n, 1'h1);
    trst_n = 1'h1;
    tck_cycle(1'h0, 1'h1);
    check(tdo_oe_n, 1'h1);
    $display("test_scan done");
  endtask

  task automatic test_first_format();
    wait_cyc(3 * FRAME_CYC);
    check({locked, gci_out}, 2'h2);
    check(tx_oe_n, 32'h0000_0000);
    check(far_end.got[4][6], far_end.pat(4, 6));
    check(far_end.got[0][0], far_end.pat(0, 0));
    $display("test_first_format done");
  endtask

  task automatic test_device_reset();
    reset_n_in = 1'h0;
    wait_cyc(3);
    reset_n_in = 1'h1;
    wait_cyc(10);
    check(tx_oe_n, 32'h0000_0000);
    // pin held low well past the least time
    reset_n_in = 1'h0;
    wait_cyc(10);
    check(tx_oe_n, 32'hFFFF_FFFF);
    // Queue is not drained while held, so eight writes fill it
    for (int i = 0; i < 8; i++) begin
      cm_valid = 1'h1;
      cm_dest  = DEST;
      cm_src   = (i == 7) ? SRC : 10'h0E0 + 10'(i);
      @(negedge clk_in);
    end
    cm_valid = 1'h0;
    wait_cyc(1);
    check(cm_ready, 1'h0);
    cm_valid = 1'h1;
    cm_src   = 10'h000;
    wait_cyc(2);
    cm_valid = 1'h0;
    reset_n_in = 1'h1;
    wait_cyc(4 * FRAME_CYC);
    check(cm_ready, 1'h1);
    check(far_end.got[3][5], far_end.pat(7, 9));
    check(far_end.got[31][31], far_end.pat(31, 31));
    $display("test_device_reset done");
  endtask

  task automatic test_gci();
    gci_mode = 1'h1;
    // Relock takes two frames, memory refill one more
    wait_cyc(5 * FRAME_CYC);
    check({locked, gci_out}, 2'h3);
    check(far_end.got[3][5], far_end.pat(7, 9));
    check(far_end.got[5][3], far_end.pat(5, 3));
    $display("test_gci done");
  endtask

  initial begin
    failures   = 0;
    checked    = 0;
    rst_in     = 1'h1;
    reset_n_in = 1'h1;
    gci_mode   = 1'h0;
    cm_valid   = 1'h0;
    cm_dest    = '0;
    cm_src     = '0;
    tck        = 1'h0;
    tms        = 1'h1;
    tdi        = 1'h1;
    // scan reset pulsed low at power-up
    trst_n     = 1'h0;
    wait_cyc(8);
    test_reset_state();
    rst_in = 1'h0;
    trst_n = 1'h1;
    wait_cyc(2);
    test_scan();
    test_first_format();
    test_device_reset();
    test_gci();
    conclude();
  end

  // Twelve frames of tests plus margin
  initial begin
    #1_800_000;
    failures++;
    $display("ERROR at %0t: run did not finish", $time);
    conclude();
  end
endmodule
